// ### hdl/asw_axis_status.sv
//
// one axis of status word 1 and status word 2, plus discrete outputs
// assumes block decode and control loop run on ref_clk; pins are async
//
`timescale 1ns/1ps
module asw_axis_status #(
  parameter int unsigned INPOS_LOW_CYC = asw_pkg::INPOS_LOW_CYC
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // decoded host blocks, one-cycle pulses unless noted
  input  wire logic             reset_cmd,
  input  wire logic             param_valid,
  input  wire logic             param_inputs_en,
  input  wire logic             param_out1_inpos,
  input  wire logic             param_out2_fault,
  input  wire logic             param_hw_start_en,
  input  wire logic             setpoint_valid,
  input  wire logic             cmd_valid,
  input  wire logic             cmd_auto,
  input  wire logic             move_start,
  input  wire logic [3:0]       move_sp_num,
  input  wire logic             seg_start,
  input  wire logic             jog_cmd,
  input  wire logic             imm_stop_cmd,
  input  wire logic             bt_write_done,
  input  wire logic             bt_write_differs,
  input  wire logic             prog_err,
  // control loop levels
  input  wire logic             profile_done,
  input  wire logic             vel_zero,
  input  wire logic             pos_settled,
  input  wire logic             fe_in_band,
  input  wire logic             pid_terms_en,
  input  wire logic             cmd_motion,
  input  wire logic             integ_at_max,
  input  wire logic             fe_excess,
  input  wire logic             pid_err_excess,
  input  wire logic             err_words_valid,
  input  wire logic             pos_words_valid,
  input  wire logic             diag_words_valid,
  input  wire asw_pkg::asw_flt_t flt_src,
  // raw discrete input pins
  input  wire asw_pkg::asw_pins_t pins,
  // status and discrete outputs
  output logic [15:0]           status_word1,
  output logic [15:0]           status_word2,
  output logic                  analog_out_en,
  output logic                  out1_inpos,
  output logic                  out2_loop_fault,
  output logic                  block_rejected
);

  // ***************************************************************
  // input synchroniser
  // ***************************************************************
  asw_pkg::asw_pins_t pins_s1_r;    // first stage, read by stage two
  asw_pkg::asw_pins_t pins_s2_r;    // safe to use
  logic               start_d_r;    // previous start level

  // two flops on every pin before any logic looks at it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pins_s1_r <= '0;
      pins_s2_r <= '0;
      start_d_r <= 1'b0;
    end else begin
      pins_s1_r <= pins;
      pins_s2_r <= pins_s1_r;
      start_d_r <= pins_s2_r.start;
    end
  end

  // ***************************************************************
  // acceptance gating
  // ***************************************************************
  logic ready_r;         // valid parameter block seen
  logic clr;             // host reset command only
  logic acc_sp;          // accepted setpoint block
  logic acc_move;        // accepted move to setpoint
  logic acc_seg;         // accepted motion segment start
  logic acc_jog;         // accepted jog
  logic acc_cmd;         // accepted command block
  logic acc_stop;        // accepted immediate stop
  logic any_req;         // something ready must gate

  assign clr      = reset_cmd;
  // until ready only a parameter block or a reset command gets through
  assign acc_sp   = setpoint_valid & ready_r;
  assign acc_move = move_start & ready_r;
  assign acc_seg  = seg_start & ready_r;
  assign acc_jog  = jog_cmd & ready_r;
  assign acc_cmd  = cmd_valid & ready_r;
  assign acc_stop = imm_stop_cmd & ready_r;
  assign any_req  = setpoint_valid | move_start | seg_start |
                    jog_cmd | cmd_valid | imm_stop_cmd;

  // one-cycle flag for a refused block
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      block_rejected <= 1'b0;
    end else begin
      block_rejected <= any_req & ~ready_r;
    end
  end

  // ***************************************************************
  // configuration latched from the parameter block
  // ***************************************************************
  logic inen_r;          // discrete inputs enabled
  logic o1cfg_r;         // output one is in-position
  logic o2cfg_r;         // output two is loop fault
  logic hwst_r;          // hardware start enabled
  logic sprcv_r;         // setpoint block received

  // ready and config: cleared by reset, loaded by parameters
  always_ff @(posedge ref_clk) begin
    if (sys_rst | clr) begin
      ready_r <= 1'b0;
      inen_r  <= 1'b0;
      o1cfg_r <= 1'b0;
      o2cfg_r <= 1'b0;
      hwst_r  <= 1'b0;
    end else if (param_valid) begin
      ready_r <= 1'b1;
      inen_r  <= param_inputs_en;
      o1cfg_r <= param_out1_inpos;
      o2cfg_r <= param_out2_fault;
      hwst_r  <= param_hw_start_en;
    end
  end

  // setpoints received
  always_ff @(posedge ref_clk) begin
    if (sys_rst | clr) begin
      sprcv_r <= 1'b0;
    end else if (acc_sp) begin
      sprcv_r <= 1'b1;
    end
  end

  // ***************************************************************
  // motion flags
  // ***************************************************************
  logic done_r;          // profile finished
  logic inpos_r;         // inside in-position band
  logic new_move;        // move or jog starts now
  logic auto_r;          // command-block auto bit

  assign new_move = acc_move | acc_seg | acc_jog;

  // a new move wins over a finishing profile in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst | clr) begin
      done_r  <= 1'b0;
      inpos_r <= 1'b0;
    end else if (new_move) begin
      done_r  <= 1'b0;
      inpos_r <= 1'b0;
    end else begin
      done_r  <= profile_done & vel_zero & pos_settled;
      inpos_r <= done_r & fe_in_band;
    end
  end

  // auto/manual bit of the last accepted command block
  always_ff @(posedge ref_clk) begin
    if (sys_rst | clr) begin
      auto_r <= 1'b0;
    end else if (acc_cmd) begin
      auto_r <= cmd_auto;
    end
  end

  // ***************************************************************
  // block transfer write toggle
  // ***************************************************************
  logic tog_r;           // inverts on each new good write

  // a write with a programming error never toggles
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tog_r <= 1'b0;
    end else if (bt_write_done & bt_write_differs & ~prog_err) begin
      tog_r <= ~tog_r;
    end
  end

  // ***************************************************************
  // active setpoint number
  // ***************************************************************
  logic [3:0] sp_r;      // shown setpoint number
  logic [3:0] sp_pend_r; // commanded, waiting for start
  logic       pend_r;    // a deferred update is waiting
  logic       hw_go;     // qualified rising start edge
  logic [3:0] sp_cmd;    // value the new move would show

  assign hw_go  = pins_s2_r.start & ~start_d_r & inen_r;
  assign sp_cmd = acc_seg ? asw_pkg::SP_SEG : move_sp_num;

  // jog clears; hardware start may hold back the update
  always_ff @(posedge ref_clk) begin
    if (sys_rst | acc_jog) begin
      sp_r      <= asw_pkg::SP_NONE;
      sp_pend_r <= asw_pkg::SP_NONE;
      pend_r    <= 1'b0;
    end else if (acc_move | acc_seg) begin
      if (hwst_r & inen_r) begin
        sp_pend_r <= sp_cmd;
        pend_r    <= 1'b1;
      end else begin
        sp_r <= sp_cmd;
      end
    end else if (pend_r & hw_go) begin
      sp_r   <= sp_pend_r;
      pend_r <= 1'b0;
    end
  end

  // ***************************************************************
  // fault flags
  // ***************************************************************
  logic [asw_pkg::N_FAULT-1:0] flt_r;   // word 2 fault bits
  logic [asw_pkg::N_FAULT-1:0] flt_set; // this cycle's causes
  logic                        pid_on;  // pid active level
  logic                        hw_stop; // recognised pin stop

  assign pid_on  = pid_terms_en & ~cmd_motion;
  assign hw_stop = ~pins_s2_r.stop_n & inen_r;
  assign flt_set = {flt_src.internal,
                    flt_src.analog,
                    flt_src.feedback,
                    flt_src.discrete,
                    hw_stop | acc_stop,
                    pid_err_excess & pid_on,
                    fe_excess};

  // two loop-error bits follow their cause; the rest latch
  // until reset so a brief fault cannot slip past the host
  generate
    for (genvar i = 0; i < asw_pkg::N_FAULT; i++) begin : g_flt
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          flt_r[i] <= 1'b0;
        end else if (i < 2) begin
          flt_r[i] <= flt_set[i];
        end else if (flt_set[i]) begin
          flt_r[i] <= 1'b1;                     // set beats clear
        end else if (clr) begin
          flt_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // status words
  // ***************************************************************
  logic [15:0] w1_nxt;   // next status word 1
  logic [15:0] w2_nxt;   // next status word 2

  // assemble both words from the flags above
  always_comb begin
    w1_nxt = asw_pkg::WORD_RST;
    w1_nxt[asw_pkg::W1_READY]  = ready_r;
    w1_nxt[asw_pkg::W1_SPRCV]  = sprcv_r;
    w1_nxt[asw_pkg::W1_DONE]   = done_r;
    w1_nxt[asw_pkg::W1_INPOS]  = inpos_r;
    w1_nxt[asw_pkg::W1_AUTO]   = auto_r &
      (pins_s2_r.auto_manual_terminal | ~inen_r);
    w1_nxt[asw_pkg::W1_PRGERR] = prog_err;
    w1_nxt[asw_pkg::W1_PID]    = pid_on;
    w1_nxt[asw_pkg::W1_TOGGLE] = tog_r;
    w1_nxt[asw_pkg::W1_INEN]   = inen_r;
    w1_nxt[15:asw_pkg::W1_PINS] = pins_s2_r;
    w2_nxt = asw_pkg::WORD_RST;                 // bit 4 reads zero
    w2_nxt[asw_pkg::W2_SPNUM +: 4] = sp_r;
    w2_nxt[asw_pkg::W2_ERRV]  = err_words_valid;
    w2_nxt[asw_pkg::W2_POSV]  = pos_words_valid;
    w2_nxt[asw_pkg::W2_DIAGV] = diag_words_valid;
    w2_nxt[asw_pkg::W2_ILIM]  = integ_at_max;
    w2_nxt[15:asw_pkg::W2_FAULT] = flt_r;
  end

  // register both words for the block read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_word1 <= asw_pkg::WORD_RST;
      status_word2 <= asw_pkg::WORD_RST;
    end else begin
      status_word1 <= w1_nxt;
      status_word2 <= w2_nxt;
    end
  end

  // ***************************************************************
  // discrete outputs and analog enable
  // ***************************************************************
  logic [asw_pkg::CNT_W-1:0] low_cnt_r; // in-position low hold
  logic                      loop_flt;  // any fault, no ilim

  // integral limit is deliberately not part of the fault
  assign loop_flt = |flt_r;

  // loop fault idles high and drops while a fault is set
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out2_loop_fault <= 1'b1;
      analog_out_en   <= 1'b0;
    end else begin
      out2_loop_fault <= ~(o2cfg_r & loop_flt);
      analog_out_en   <= ready_r & ~loop_flt;
    end
  end

  // once low, the output stays low for the whole hold time so a
  // start input on another axis can see the pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out1_inpos <= 1'b0;
      low_cnt_r  <= '0;
    end else if (out1_inpos & ~(o1cfg_r & inpos_r)) begin
      out1_inpos <= 1'b0;
      low_cnt_r  <= asw_pkg::CNT_W'(INPOS_LOW_CYC - 1);
    end else if (low_cnt_r != '0) begin
      low_cnt_r  <= low_cnt_r - 1'b1;
    end else begin
      out1_inpos <= o1cfg_r & inpos_r;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic [asw_pkg::CNT_W-1:0] chk_low_r; // cycles output one low

  // reset counts as a long low time: it is not a falling edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chk_low_r <= '1;
    end else if (out1_inpos) begin
      chk_low_r <= '0;
    end else if (chk_low_r != '1) begin
      chk_low_r <= chk_low_r + 1'b1;
    end
  end

  ready_on_param_a: assert property (
    param_valid & ~clr |=> ready_r ##1 status_word1[0])
    else $error("ready not set after parameter block");
  refuse_blocks_a: assert property (
    setpoint_valid & ~ready_r & ~clr |=> block_rejected & ~sprcv_r)
    else $error("block taken while not ready");
  done_clear_a: assert property (
    new_move & ~clr |=> ~done_r ##1 ~status_word1[2])
    else $error("done survived a new move");
  inpos_needs_done_a: assert property (
    inpos_r |-> $past(done_r))
    else $error("in-position without done");
  inpos_hold_a: assert property (
    $rose(out1_inpos) |-> $past(chk_low_r) >= INPOS_LOW_CYC - 1)
    else $error("output one low pulse too short");
  toggle_flip_a: assert property (
    bt_write_done & bt_write_differs & ~prog_err
      |=> tog_r != $past(tog_r))
    else $error("write toggle missed");
  spnum_jog_a: assert property (
    acc_jog |=> sp_r == asw_pkg::SP_NONE ##1
      status_word2[3:0] == asw_pkg::SP_NONE)
    else $error("setpoint number not cleared by jog");
  spnum_defer_a: assert property (
    acc_move & hwst_r & inen_r & ~acc_jog |=> $stable(sp_r))
    else $error("setpoint number updated before start");
  fault_out_a: assert property (
    o2cfg_r & loop_flt |=> ~out2_loop_fault)
    else $error("loop fault output not asserted");
  ilim_no_fault_a: assert property (
    integ_at_max & ~loop_flt & ~(|flt_set) |=> ~(|flt_r) ##1
      out2_loop_fault)
    else $error("integral limit caused loop fault");

  cov_ready_c: cover property (param_valid ##1 acc_sp);
  cov_inpos_c: cover property ($rose(inpos_r) ##1 out1_inpos);
  cov_fault_c: cover property ($fell(out2_loop_fault));
  cov_defer_c: cover property (pend_r ##1 hw_go);

endmodule

// ### hdl/asw_pkg.sv
//
// constants and carrier types for the per-axis status word logic
// assumes one 100 MHz clock and one axis for each instance
//
// Summary of operation
// - ready clears on reset, sets on parameters
// - setpoint, motion, command blocks refused until ready
// - setpoints-received sets on accepted setpoint block
// - done sets at settled profile end, clears on move
// - in-position needs done and band; drives output one
// - in-position output held low at least 16 ms
// - auto mode is command bit and effective terminal
// - programming error follows the illegal-field condition
// - pid active while terms enabled, off in motion
// - toggle bit inverts on each new valid write
// - inputs-enabled set from parameter block, reset clears
// - bits nine to fifteen mirror raw input pins
// - setpoint number 1 to 13, 15 for segment
// - setpoint number zero at powerup and on jog
// - hardware start defers setpoint number update
// - three flags mark content of following words
// - integral limit flag follows limit, no fault
// - excess following error flag and loop fault
// - pid error flag while pid active, loop fault
// - immediate stop flag from pin or command
// - discrete input and analog faults flag, fault out
// - feedback and internal faults flag, fault out
// - loop fault output idles high, low on fault
// - in-position output low on move, high in band
package asw_pkg;
  // status word 1 bit positions
  localparam int unsigned W1_READY  = 0;
  localparam int unsigned W1_SPRCV  = 1;
  localparam int unsigned W1_DONE   = 2;
  localparam int unsigned W1_INPOS  = 3;
  localparam int unsigned W1_AUTO   = 4;
  localparam int unsigned W1_PRGERR = 5;
  localparam int unsigned W1_PID    = 6;
  localparam int unsigned W1_TOGGLE = 7;
  localparam int unsigned W1_INEN   = 8;
  localparam int unsigned W1_PINS   = 9;   // lowest raw pin bit
  // status word 2 bit positions
  localparam int unsigned W2_SPNUM  = 0;   // four bits
  localparam int unsigned W2_ERRV   = 5;
  localparam int unsigned W2_POSV   = 6;
  localparam int unsigned W2_DIAGV  = 7;
  localparam int unsigned W2_ILIM   = 8;
  localparam int unsigned W2_FAULT  = 9;   // lowest fault bit
  localparam int unsigned N_FAULT   = 7;
  // setpoint field values
  localparam logic [3:0] SP_NONE = 4'h0;
  localparam logic [3:0] SP_SEG  = 4'hF;
  localparam logic [3:0] SP_MAX  = 4'hD;
  // timing
  localparam int unsigned CLK_KHZ      = 100000;
  localparam int unsigned INPOS_LOW_MS = 16;
  localparam int unsigned INPOS_LOW_CYC = INPOS_LOW_MS * CLK_KHZ;
  localparam int unsigned CNT_W = 21;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // raw discrete input pins, order as in status word 1
  typedef struct packed {
    logic in2;       // user input 2
    logic in1;       // user input 1
    logic jog_rev;   // jog reverse
    logic jog_fwd;   // jog forward
    logic stop_n;    // hardware stop, low true
    logic start;     // hardware start
    logic auto_manual_terminal;
  } asw_pins_t;
  // fault detector sources
  typedef struct packed {
    logic internal;  // backplane-powered circuit
    logic analog;    // analog power or circuit
    logic feedback;  // transducer interface
    logic discrete;  // discrete input power or circuit
  } asw_flt_t;
endpackage

// ### sim/asw_host_model.sv
// host model: turns bench block requests into decoded block pulses
// assumes requests are one-cycle levels set just after ref_clk rises
`timescale 1ns/1ps
module asw_host_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // bench request: op 0 param .. 7 reset command
  input  wire logic       req,
  input  wire logic [2:0] op,
  input  wire logic       rude,
  // decoded pulses, one bit per op, and write-done
  output logic [7:0]      blk,
  output logic            bt_done
);
  logic ready_seen_r;  // parameters sent since last reset

  // pulse the block; a polite host drops gated blocks until ready
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      blk     <= 8'h00;
      bt_done <= 1'b0;
    end else begin
      blk     <= 8'h00;
      bt_done <= req;
      // rude lets a scenario break the order on purpose
      if (req && (op == 3'h0 || op == 3'h7 || ready_seen_r || rude)) begin
        blk[op] <= 1'b1;
      end
    end
  end

  // parameters arm the host, a reset command disarms it
  always_ff @(posedge ref_clk) begin
    if (sys_rst || (req && op == 3'h7)) begin
      ready_seen_r <= 1'b0;
    end else if (req && op == 3'h0) begin
      ready_seen_r <= 1'b1;
    end
  end
endmodule

// ### sim/asw_axis_status_tb_top.sv
// bench for one axis of status words and discrete outputs
// assumes the host model and a 20-cycle in-position low hold
`timescale 1ns/1ps
module asw_axis_status_tb_top;
  logic ref_clk = 1'b0, sys_rst = 1'b1, req = 1'b0, rude = 1'b0;
  logic [2:0] op = 3'h0, wv = 3'h0;
  logic [7:0] blk;
  logic bt_done, cauto = 1'b0, differs = 1'b1, perr = 1'b0;
  logic pdone = 1'b0, vz = 1'b0, pset = 1'b0, band = 1'b0, pid = 1'b0;
  logic motion = 1'b0, imax = 1'b0, fex = 1'b0, pex = 1'b0;
  logic hwst = 1'b0;
  logic [3:0] spn = 4'h5;
  asw_pkg::asw_flt_t flt = '0;
  asw_pkg::asw_pins_t pins = 7'h04;  // stop_n high: no stop
  logic [15:0] w1, w2;
  logic aen, out1, out2, rej;
  int mismatches = 0, cmp_count = 0;

  always #5 ref_clk = ~ref_clk;  // 100 MHz

  asw_host_model i_asw_host_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .req(req), .op(op), .rude(rude), .blk(blk), .bt_done(bt_done));

  asw_axis_status #(.INPOS_LOW_CYC(20)) i_asw_axis_status (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reset_cmd(blk[7]),
    .param_valid(blk[0]), .param_inputs_en(1'b1),
    .param_out1_inpos(1'b1), .param_out2_fault(1'b1),
    .param_hw_start_en(hwst), .setpoint_valid(blk[1]),
    .cmd_valid(blk[2]), .cmd_auto(cauto), .move_start(blk[3]),
    .move_sp_num(spn), .seg_start(blk[4]), .jog_cmd(blk[5]),
    .imm_stop_cmd(blk[6]), .bt_write_done(bt_done),
    .bt_write_differs(differs), .prog_err(perr), .profile_done(pdone),
    .vel_zero(vz), .pos_settled(pset), .fe_in_band(band),
    .pid_terms_en(pid), .cmd_motion(motion), .integ_at_max(imax),
    .fe_excess(fex), .pid_err_excess(pex), .err_words_valid(wv[0]),
    .pos_words_valid(wv[1]), .diag_words_valid(wv[2]), .flt_src(flt),
    .pins(pins), .status_word1(w1), .status_word2(w2),
    .analog_out_en(aen), .out1_inpos(out1), .out2_loop_fault(out2),
    .block_rejected(rej));

  // ****************************************
  // helpers: one step past the edge, compares
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask

  // one host block; room left for the two-edge status latency
  task automatic send(input logic [2:0] o);
    op = o;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    tick(5);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reject;
    logic hit;
    hit = 1'b0;
    chk(w1, 16'h0000);
    chk(w2, 16'h0000);
    chb(out2, 1'b1);
    rude = 1'b1;
    // a setpoint block, then a move, both ahead of the parameters
    for (int k = 0; k < 2; k++) begin
      hit = 1'b0;
      op = (k == 0) ? 3'h1 : 3'h3;
      req = 1'b1;
      tick(1);
      req = 1'b0;
      repeat (6) begin
        tick(1);
        hit = hit | rej;
      end
      chb(hit, 1'b1);
    end
    rude = 1'b0;
    chb(w1[1], 1'b0);
    chk({12'h0, w2[3:0]}, 16'h0000);
    $display("t_reject done");
  endtask

  task automatic t_ready;
    send(3'h0);
    chb(w1[0], 1'b1);
    chb(w1[8], 1'b1);
    chb(aen, 1'b1);
    pins = 7'h55;
    cauto = 1'b1;
    send(3'h2);
    chk({9'h0, w1[15:9]}, 16'h0055);
    chb(w1[4], 1'b1);
    pins = 7'h54;
    pid = 1'b1;
    tick(5);
    chb(w1[4], 1'b0);
    chb(w1[6], 1'b1);
    motion = 1'b1;
    tick(3);
    chb(w1[6], 1'b0);
    motion = 1'b0;
    pins = 7'h04;
    $display("t_ready done");
  endtask

  task automatic t_move;
    int n;
    send(3'h1);
    chb(w1[1], 1'b1);
    send(3'h3);
    chk({12'h0, w2[3:0]}, 16'h0005);
    chb(w1[2], 1'b0);
    {pdone, vz, pset} = 3'h7;
    tick(3);
    chb(w1[2], 1'b1);
    chb(w1[3], 1'b0);
    band = 1'b1;
    tick(4);
    chb(w1[3], 1'b1);
    chb(out1, 1'b1);
    send(3'h4);
    chk({12'h0, w2[3:0]}, 16'h000F);
    // the segment start dropped output one; let its hold run out
    n = 0;
    while (out1 !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chb(out1, 1'b1);
    op = 3'h5;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    n = 0;
    while (out1 === 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chb(out1, 1'b0);
    n = 0;
    // in-band levels stay up, so only the hold keeps the output low
    while (out1 !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chb(n >= 20, 1'b1);
    chk({12'h0, w2[3:0]}, 16'h0000);
    {pdone, vz, pset, band} = 4'h0;
    $display("t_move done");
  endtask

  task automatic t_toggle;
    logic b;
    b = w1[7];
    send(3'h2);
    chb(w1[7], ~b);
    perr = 1'b1;
    send(3'h2);
    chb(w1[7], ~b);
    chb(w1[5], 1'b1);
    perr = 1'b0;
    tick(3);
    chb(w1[5], 1'b0);
    $display("t_toggle done");
  endtask

  task automatic t_fault;
    imax = 1'b1;
    wv = 3'h5;
    tick(3);
    chb(w2[8], 1'b1);
    chb(out2, 1'b1);
    chk({13'h0, w2[7:5]}, 16'h0005);
    imax = 1'b0;
    fex = 1'b1;
    tick(3);
    chb(w2[9], 1'b1);
    chb(out2, 1'b0);
    fex = 1'b0;
    pex = 1'b1;
    tick(3);
    chb(w2[10], 1'b1);
    pex = 1'b0;
    tick(3);
    chb(out2, 1'b1);
    for (int i = 0; i < 4; i++) begin
      flt = asw_pkg::asw_flt_t'(4'h1 << i);
      tick(1);
      flt = '0;
      tick(3);
      chb(w2[12 + i], 1'b1);
      chb(out2, 1'b0);
    end
    send(3'h6);
    chb(w2[11], 1'b1);
    send(3'h7);
    chb(w1[0], 1'b0);
    chb(w1[1], 1'b0);
    chk({11'h0, w2[15:11]}, 16'h0000);
    $display("t_fault done");
  endtask

  // hardware start enabled: the number waits for a start edge
  task automatic t_defer;
    hwst = 1'b1;
    send(3'h0);
    spn = 4'h9;
    send(3'h3);
    chk({12'h0, w2[3:0]}, 16'h0000);
    pins = 7'h06;
    tick(5);
    chk({12'h0, w2[3:0]}, 16'h0009);
    pins = 7'h04;
    hwst = 1'b0;
    spn = 4'h5;
    $display("t_defer done");
  endtask

  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #50000;
    mismatches++;
    stop_test();
  end

  initial begin
    tick(12);
    sys_rst = 1'b0;
    tick(1);
    t_reject();
    t_ready();
    t_move();
    t_toggle();
    t_fault();
    t_defer();
    stop_test();
  end
endmodule
